// ### shared/dual_dac_pkg.sv
// constants for the dual converter input interface
package dual_dac_pkg;
    localparam int          DATA_W        = 10;
    localparam int          LATENCY       = 4;
    localparam logic [9:0]  CODE_MAX      = 10'h3ff;
    localparam int          MAX_RATE_MSPS = 275;
    // register map, byte addresses
    localparam logic [7:0]  CTRL_ADDR     = 8'h00;
    localparam logic [7:0]  STATUS_ADDR   = 8'h04;
    localparam int          CTRL_DUAL_BIT = 0;
    localparam int          CTRL_GAIN_BIT = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h1;
    localparam int          STAT_A_LSB    = 0;
    localparam int          STAT_B_LSB    = 10;
    localparam int          STAT_DIV_BIT  = 20;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage : dual_dac_pkg

// ### tb/host_source.sv
// host logic model driving sample words and strobes into the converter inputs
`timescale 1ns/1ps
module host_source (
    input  wire logic       clock_in,
    output logic [9:0]      chan_a_data_out,
    output logic [9:0]      chan_b_data_out,
    output logic [1:0]      dual_strobe_out,
    output logic [1:0]      dual_clock_out,
    output logic            shared_strobe_out,
    output logic            shared_clock_out,
    output logic            select_out,
    output logic            pairing_reset_out
);
    // idle levels at time zero, pairing held until the bench releases it
    initial begin
        chan_a_data_out   = 10'h000;
        chan_b_data_out   = 10'h000;
        dual_strobe_out   = 2'h0;
        dual_clock_out    = 2'h0;
        shared_strobe_out = 1'b0;
        shared_clock_out  = 1'b0;
        select_out        = 1'b0;
        pairing_reset_out = 1'b1;
    end

    // one update per enabled channel, clock tied to write; 4 cycles keeps us far below 275 msps
    task automatic dual_update(input logic [9:0] a, input logic [9:0] b, input logic [1:0] en);
        @(posedge clock_in);
        dual_strobe_out <= en;
        dual_clock_out  <= en;
        chan_a_data_out <= a;
        chan_b_data_out <= b;
        repeat (2) @(posedge clock_in);
        dual_strobe_out <= 2'h0;
        dual_clock_out  <= 2'h0;
        // hold time is over, so the old word must not linger on the bus
        chan_a_data_out <= ~a;
        chan_b_data_out <= ~b;
        @(posedge clock_in);
        #1;
    endtask : dual_update

    // one interleaved word on bus a, bus b carries junk
    task automatic iq_word(input logic [9:0] w, input logic [9:0] junk, input logic sel);
        @(posedge clock_in);
        shared_strobe_out <= 1'b1;
        shared_clock_out  <= 1'b1;
        chan_a_data_out   <= w;
        chan_b_data_out   <= junk;
        select_out        <= sel;
        repeat (2) @(posedge clock_in);
        shared_strobe_out <= 1'b0;
        shared_clock_out  <= 1'b0;
        chan_a_data_out   <= ~w;
        @(posedge clock_in);
        #1;
    endtask : iq_word

    task automatic pairing(input logic v);
        @(posedge clock_in);
        pairing_reset_out <= v;
    endtask : pairing
endmodule : host_source

// ### tb/tb_dual_dac_input_interface.sv
// self-checking bench for the dual converter input interface
`timescale 1ns/1ps
module tb_dual_dac_input_interface;
    logic        clock_in   = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        hsel       = 1'b0;
    logic        hwrite     = 1'b0;
    logic [1:0]  htrans     = 2'h0;
    logic [31:0] haddr      = 32'h0;
    logic [31:0] hwdata     = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, div_clk, bias_b, sstb, sclk, sel, prst;
    logic [9:0]  a_data, b_data, a_true, a_comp, b_true, b_comp, wa, wb;
    logic [1:0]  dstb, dclk;
    logic [9:0]  qa[$];
    logic [9:0]  qb[$];
    int          n_mismatch = 0;
    int          checks     = 0;
    int          div_rises  = 0;
    int unsigned seed       = 76041;

    // 250 mhz clock and a count of divided clock rises
    always #2 clock_in = ~clock_in;
    always @(posedge div_clk) div_rises++;

    host_source host_u (
        .clock_in(clock_in), .chan_a_data_out(a_data), .chan_b_data_out(b_data),
        .dual_strobe_out(dstb), .dual_clock_out(dclk), .shared_strobe_out(sstb),
        .shared_clock_out(sclk), .select_out(sel), .pairing_reset_out(prst)
    );

    dual_dac_input dut_u (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .chan_a_data_in(a_data), .chan_b_data_in(b_data),
        .chan_a_write_strobe_in(dstb[0]), .chan_b_write_strobe_in(dstb[1]),
        .chan_a_update_clock_in(dclk[0]), .chan_b_update_clock_in(dclk[1]),
        .shared_write_strobe_in(sstb), .shared_update_clock_in(sclk),
        .channel_select_line_in(sel), .pairing_reset_in(prst),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .chan_a_true_current_out(a_true), .chan_a_complement_current_out(a_comp),
        .chan_b_true_current_out(b_true), .chan_b_complement_current_out(b_comp),
        .divided_converter_clock_out(div_clk), .bias_resistor_b_used_out(bias_b)
    );

    function automatic logic [9:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[9:0];
    endfunction : rnd

    task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic wrap_up();
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // single word transfer; the master never assumes a wait count
    task automatic ahb(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= adr;
        hwrite <= wr;
        htrans <= dual_dac_pkg::HTRANS_NONSEQ;
        do begin
            @(posedge clock_in);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clock_in);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : ahb

    // model: each channel shows the word written four of its own updates earlier
    task automatic dual_step(input logic [1:0] en);
        logic [9:0] a;
        logic [9:0] b;
        a = rnd();
        b = rnd();
        host_u.dual_update(a, b, en);
        if (en[0]) qa.push_back(a);
        if (en[1]) qb.push_back(b);
        chk_code(a_true, qa[$-4]);
        chk_code(b_true, qb[$-4]);
        chk_code(a_comp, dual_dac_pkg::CODE_MAX - qa[$-4]);
        chk_code({9'h0, div_clk}, 10'h000);
    endtask : dual_step

    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (5) begin
            qa.push_back(10'h000);
            qb.push_back(10'h000);
        end
        repeat (20) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        chk_code({9'h0, bias_b}, 10'h001);
        ahb(1'b0, {24'h0, dual_dac_pkg::CTRL_ADDR}, 32'h0);
        chk_word(rd, 32'h0000_0001);
        chk_word({30'h0, hreadyout, hresp}, 32'h0000_0002);
        // full rate on both channels, then the channels take turns
        for (int i = 0; i < 16; i++) dual_step(i < 8 ? 2'h3 : {i[0], ~i[0]});
        ahb(1'b0, {24'h0, dual_dac_pkg::STATUS_ADDR}, 32'h0);
        chk_word(rd, {12'h0, qb[$-4], qa[$-4]});
        ahb(1'b1, 32'h0000_0010, 32'h0000_0003);
        ahb(1'b1, {24'h0, dual_dac_pkg::CTRL_ADDR}, 32'h0000_0002);
        ahb(1'b0, 32'h0000_0010, 32'h0);
        chk_word(rd, 32'h0);
        ahb(1'b0, {24'h0, dual_dac_pkg::CTRL_ADDR}, 32'h0);
        chk_word(rd, 32'h0000_0002);
        chk_code({9'h0, bias_b}, 10'h000);
        // divided clock must stay low while pairing is held
        repeat (3) begin
            host_u.iq_word(rnd(), rnd(), 1'b1);
            chk_code({9'h0, div_clk}, 10'h000);
        end
        host_u.pairing(1'b0);
        div_rises = 0;
        // last pair repeats four times, just enough for the pipe to drain at its depth of four
        for (int i = 0; i < 10; i++) begin
            if (i < 6) begin
                wa = rnd();
                wb = rnd();
            end
            host_u.iq_word(wa, rnd(), 1'b1);
            if (i == 0) chk_code(div_rises[9:0], 10'h001);
            host_u.iq_word(wb, rnd(), 1'b0);
        end
        chk_code(div_rises[9:0], 10'h00a);
        chk_code(a_true, wa);
        chk_code(b_true, wb);
        chk_code(b_comp, dual_dac_pkg::CODE_MAX - wb);
        wrap_up();
    end
endmodule : tb_dual_dac_input_interface

// ### verilog/dual_dac_input.sv
// input latches, converter latches and register slave of the dual converter
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module dual_dac_input #(
    parameter int DATA_W  = dual_dac_pkg::DATA_W,
    parameter int LATENCY = dual_dac_pkg::LATENCY
) (
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    input  wire logic [DATA_W-1:0] chan_a_data_in,
    input  wire logic [DATA_W-1:0] chan_b_data_in,
    input  wire logic              chan_a_write_strobe_in,
    input  wire logic              chan_b_write_strobe_in,
    input  wire logic              chan_a_update_clock_in,
    input  wire logic              chan_b_update_clock_in,
    input  wire logic              shared_write_strobe_in,
    input  wire logic              shared_update_clock_in,
    input  wire logic              channel_select_line_in,
    input  wire logic              pairing_reset_in,
    input  wire logic              hsel_in,
    input  wire logic [31:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire logic [31:0]       hwdata_in,
    input  wire logic              hready_in,
    output logic [31:0]            hrdata_out,
    output logic                   hreadyout_out,
    output logic                   hresp_out,
    output logic [DATA_W-1:0]      chan_a_true_current_out,
    output logic [DATA_W-1:0]      chan_a_complement_current_out,
    output logic [DATA_W-1:0]      chan_b_true_current_out,
    output logic [DATA_W-1:0]      chan_b_complement_current_out,
    output logic                   divided_converter_clock_out,
    output logic                   bias_resistor_b_used_out
);
    // control register bits
    logic                      dual_mode;
    logic                      gain_set_select;
    // previous levels for edge detection
    logic                      wa_q, wb_q, ca_q, cb_q, ws_q, cs_q;
    logic                      wa_rise, wb_rise, ca_rise, cb_rise;
    logic                      ws_rise, ws_fall, cs_rise, div_rise;
    // per-channel latches and pipeline
    logic [DATA_W-1:0]         in_latch [2];
    logic [DATA_W-1:0]         present  [2];
    logic [DATA_W-1:0]         stage    [2][LATENCY];
    logic [DATA_W-1:0]         comp     [2];
    logic [1:0]                update;
    // bus address-phase decode and data-phase state
    logic                      wr_pend;
    logic [7:0]                wr_addr;
    logic                      addr_ok;
    logic [31:0]               next_rdata;

    // strobes are synchronous inputs, so one delayed copy gives the edges
    // sampling them as data caps the accepted update rate at half of clock_in
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wa_q <= 1'b0;
            wb_q <= 1'b0;
            ca_q <= 1'b0;
            cb_q <= 1'b0;
            ws_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            wa_q <= chan_a_write_strobe_in;
            wb_q <= chan_b_write_strobe_in;
            ca_q <= chan_a_update_clock_in;
            cb_q <= chan_b_update_clock_in;
            ws_q <= shared_write_strobe_in;
            cs_q <= shared_update_clock_in;
        end
    end

    // edge terms, gated by the bus mode
    assign wa_rise  = dual_mode && chan_a_write_strobe_in && !wa_q;
    assign wb_rise  = dual_mode && chan_b_write_strobe_in && !wb_q;
    assign ca_rise  = dual_mode && chan_a_update_clock_in && !ca_q;
    assign cb_rise  = dual_mode && chan_b_update_clock_in && !cb_q;
    assign ws_rise  = !dual_mode && shared_write_strobe_in && !ws_q;
    assign ws_fall  = !dual_mode && !shared_write_strobe_in && ws_q;
    assign cs_rise  = !dual_mode && shared_update_clock_in && !cs_q;
    assign div_rise = cs_rise && !pairing_reset_in && !divided_converter_clock_out;
    // converter latch update per channel
    assign update[0] = dual_mode ? ca_rise : div_rise;
    assign update[1] = dual_mode ? cb_rise : div_rise;

    // divide-by-two converter clock, pinned low by the pairing reset
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || dual_mode || pairing_reset_in) begin
            divided_converter_clock_out <= 1'b0;
        end else if (cs_rise) begin
            divided_converter_clock_out <= !divided_converter_clock_out;
        end
    end

    // input latch a: own strobe in dual mode, select high in interleaved
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            in_latch[0] <= '0;
        end else if (wa_rise) begin
            in_latch[0] <= chan_a_data_in;
        end else if (ws_rise && channel_select_line_in) begin
            in_latch[0] <= chan_a_data_in;
        end
    end

    // input latch b: bus b only in dual mode; holds when unselected
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            in_latch[1] <= '0;
        end else if (wb_rise) begin
            in_latch[1] <= chan_b_data_in;
        end else if (ws_rise && !channel_select_line_in) begin
            in_latch[1] <= chan_a_data_in;
        end else begin
            in_latch[1] <= in_latch[1];
        end
    end

    // interleaved words handed on together at the write falling edge
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            present[0] <= '0;
            present[1] <= '0;
        end else if (ws_fall) begin
            present[0] <= in_latch[0];
            present[1] <= in_latch[1];
        end
    end

    // converter latch plus output pipeline; the last stage is the output
    // word, so a write tied to its clock shows after exactly four updates
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        always_ff @(posedge clock_in) begin
            if (sys_rst_in) begin
                for (int s = 0; s < LATENCY; s++) begin
                    stage[ch][s] <= '0;
                end
                comp[ch] <= dual_dac_pkg::CODE_MAX;
            end else if (update[ch]) begin
                stage[ch][0] <= dual_mode ? in_latch[ch] : present[ch];
                for (int s = 1; s < LATENCY; s++) begin
                    stage[ch][s] <= stage[ch][s-1];
                end
                comp[ch] <= dual_dac_pkg::CODE_MAX - stage[ch][LATENCY-2];
            end
        end
    end

    // output words straight from the pipeline flops
    assign chan_a_true_current_out       = stage[0][LATENCY-1];
    assign chan_b_true_current_out       = stage[1][LATENCY-1];
    assign chan_a_complement_current_out = comp[0];
    assign chan_b_complement_current_out = comp[1];

    // bias steering follows the gain select bit
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            bias_resistor_b_used_out <= 1'b1;
        end else begin
            bias_resistor_b_used_out <= !gain_set_select;
        end
    end

    // address phase decode; zero wait states, so hready is never dropped
    assign addr_ok = hsel_in && hready_in && (htrans_in == dual_dac_pkg::HTRANS_NONSEQ);

    // read data built in the address phase so the data phase sees a flop
    always_comb begin
        next_rdata = dual_dac_pkg::ZERO_WORD;
        unique case (haddr_in[7:0])
            dual_dac_pkg::CTRL_ADDR: begin
                next_rdata[dual_dac_pkg::CTRL_DUAL_BIT] = dual_mode;
                next_rdata[dual_dac_pkg::CTRL_GAIN_BIT] = gain_set_select;
            end
            dual_dac_pkg::STATUS_ADDR: begin
                next_rdata[dual_dac_pkg::STAT_A_LSB +: 10] = stage[0][LATENCY-1];
                next_rdata[dual_dac_pkg::STAT_B_LSB +: 10] = stage[1][LATENCY-1];
                next_rdata[dual_dac_pkg::STAT_DIV_BIT]     = divided_converter_clock_out;
            end
            default: begin
                next_rdata = dual_dac_pkg::ZERO_WORD;  // unmapped reads zero
            end
        endcase
        if (haddr_in[31:8] != 24'h00_0000) begin
            next_rdata = dual_dac_pkg::ZERO_WORD;
        end
    end

    // bus response and read data
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            hrdata_out    <= dual_dac_pkg::ZERO_WORD;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;  // always okay
            if (addr_ok && !hwrite_in) begin
                hrdata_out <= next_rdata;
            end
        end
    end

    // write address held over into the data phase
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite_in && (haddr_in[31:8] == 24'h00_0000);
            wr_addr <= haddr_in[7:0];
        end
    end

    // control register; mode change mid-stream is the user's hazard
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            dual_mode       <= dual_dac_pkg::CTRL_RESET[dual_dac_pkg::CTRL_DUAL_BIT];
            gain_set_select <= dual_dac_pkg::CTRL_RESET[dual_dac_pkg::CTRL_GAIN_BIT];
        end else if (wr_pend && wr_addr == dual_dac_pkg::CTRL_ADDR) begin
            dual_mode       <= hwdata_in[dual_dac_pkg::CTRL_DUAL_BIT];
            gain_set_select <= hwdata_in[dual_dac_pkg::CTRL_GAIN_BIT];
        end
    end

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_inter_write_hi;
        !dual_mode && shared_write_strobe_in && !ws_q && channel_select_line_in;
    endsequence
    sequence s_inter_write_lo;
        !dual_mode && shared_write_strobe_in && !ws_q && !channel_select_line_in;
    endsequence

    div_held_low_a: assert property (pairing_reset_in |=> !divided_converter_clock_out)
        else $error("divided clock not low under pairing reset");
    div_toggle_a: assert property (
        !dual_mode && !pairing_reset_in && shared_update_clock_in && !cs_q
        |=> divided_converter_clock_out != $past(divided_converter_clock_out))
        else $error("divided clock did not toggle");
    div_start_a: assert property (
        $fell(pairing_reset_in) && !dual_mode |-> !divided_converter_clock_out)
        else $error("divided clock not low after pairing release");
    capture_a_a: assert property (
        dual_mode && chan_a_write_strobe_in && !wa_q
        |=> in_latch[0] == $past(chan_a_data_in))
        else $error("channel a word not captured");
    route_hi_a: assert property (s_inter_write_hi
        |=> in_latch[0] == $past(chan_a_data_in) && in_latch[1] == $past(in_latch[1]))
        else $error("select high routing wrong");
    route_lo_a: assert property (s_inter_write_lo
        |=> in_latch[1] == $past(chan_a_data_in) && in_latch[0] == $past(in_latch[0]))
        else $error("select low routing wrong");
    present_fall_a: assert property (
        !dual_mode && !shared_write_strobe_in && ws_q
        |=> present[0] == $past(in_latch[0]) && present[1] == $past(in_latch[1]))
        else $error("words not presented on falling write");
    out_complement_a: assert property (
        $past(update[0]) |-> chan_a_complement_current_out
            == dual_dac_pkg::CODE_MAX - chan_a_true_current_out)
        else $error("complement output mismatch");
    chan_iso_a: assert property (
        dual_mode && !(chan_a_write_strobe_in && !wa_q) |=> $stable(in_latch[0]))
        else $error("channel a latch moved without its strobe");
    gain_bias_a: assert property (gain_set_select |=> !bias_resistor_b_used_out)
        else $error("bias b still used in shared gain mode");

    // dual-mode channel events, then pipeline, divider and interleaved hold checks
    sequence s_dual_upd_a;
        dual_mode && chan_a_update_clock_in && !ca_q;
    endsequence
    sequence s_dual_write_b;
        dual_mode && chan_b_write_strobe_in && !wb_q;
    endsequence

    upd_latch_a: assert property (
        s_dual_upd_a |=> stage[0][0] == $past(in_latch[0]))
        else $error("channel a converter latch not loaded");
    capture_b_a: assert property (
        s_dual_write_b |=> in_latch[1] == $past(chan_b_data_in))
        else $error("channel b word not captured");
    pipe_out_a: assert property (
        update[0] |=> chan_a_true_current_out == $past(stage[0][LATENCY-2]))
        else $error("channel a pipeline did not advance");
    pipe_out_b_a: assert property (
        update[1] |=> chan_b_true_current_out == $past(stage[1][LATENCY-2]))
        else $error("channel b pipeline did not advance");
    comp_b_a: assert property (
        $past(update[1]) |-> chan_b_complement_current_out
            == dual_dac_pkg::CODE_MAX - chan_b_true_current_out)
        else $error("channel b complement output mismatch");
    dual_div_low_a: assert property (
        dual_mode |=> !divided_converter_clock_out)
        else $error("divided clock running in dual mode");
    iq_hold_a: assert property (
        !dual_mode && !(shared_write_strobe_in && !ws_q)
        |=> $stable(in_latch[0]) && $stable(in_latch[1]))
        else $error("interleaved latch moved without write rise");
    present_hold_a: assert property (
        !dual_mode && !(!shared_write_strobe_in && ws_q)
        |=> $stable(present[0]) && $stable(present[1]))
        else $error("presented words moved without write fall");
endmodule : dual_dac_input
